//--- pkg/nbp_pkg.sv
// nbp_pkg: constants and types of the block-protect and command gate.
// assumes a 200 MHz core clock and a host serial clock unrelated to it.
package nbp_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS   = 5;
  localparam int T_PAGE_READ_NS  = 5000;
  localparam int T_PROGRAM_NS    = 10000;
  localparam int T_ERASE_NS      = 20000;
  localparam int PAGE_READ_CYC   = (T_PAGE_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROGRAM_CYC     = (T_PROGRAM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYC       = (T_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_CNT_W      = 16;

  // ************************************************************
  // operation codes
  // ************************************************************
  localparam logic [7:0] OP_READ_ID   = 8'h9F;
  localparam logic [7:0] OP_RD_SR_A   = 8'h0F;
  localparam logic [7:0] OP_RD_SR_B   = 8'h05;
  localparam logic [7:0] OP_WR_SR_A   = 8'h1F;
  localparam logic [7:0] OP_WR_SR_B   = 8'h01;
  localparam logic [7:0] OP_WR_EN     = 8'h06;
  localparam logic [7:0] OP_WR_DIS    = 8'h04;
  localparam logic [7:0] OP_ERASE     = 8'hD8;
  localparam logic [7:0] OP_PROG_EXEC = 8'h10;
  localparam logic [7:0] OP_PAGE_READ = 8'h13;

  // ************************************************************
  // identification, arbitrary neutral values
  // ************************************************************
  localparam logic [7:0]  MAKER_CODE = 8'h5A;   // arbitrary value
  localparam logic [15:0] PART_CODE  = 16'h1234; // arbitrary value

  // ************************************************************
  // status registers and fields
  // ************************************************************
  localparam logic [3:0] SR_PROT_SEL = 4'hA;
  localparam logic [3:0] SR_STAT_SEL = 4'hC;
  localparam int SR1_CODE_LSB = 3;
  localparam int SR1_TB_BIT   = 2;
  localparam int SR3_BUSY_BIT = 0;
  localparam int SR3_WEL_BIT  = 1;
  localparam logic [3:0] CODE_RST = 4'h0;
  localparam logic       TB_RST   = 1'b0;

  // ************************************************************
  // array geometry and protect codes
  // ************************************************************
  localparam int BLOCK_W   = 12;
  localparam int PAGE_W    = 18;
  localparam int BLOCK_LSB = 6;
  localparam logic [23:0] PAGE_KEEP_MASK = 24'h03FFFF;
  localparam logic [3:0]  CODE_ALL       = 4'hB;
  localparam logic [1:0]  CODE_ALL_HI    = 2'h3;
  localparam logic [11:0] BLOCK_ONES     = 12'hFFF;
  localparam logic [2:0]  BYTE_IDX_MAX   = 3'h7;

  typedef logic [BLOCK_W-1:0] nbp_block_t;
  typedef logic [PAGE_W-1:0]  nbp_page_t;
  typedef enum logic [1:0] {OPK_NONE, OPK_ERASE, OPK_PROG, OPK_READ} nbp_opk_t;

endpackage

//--- logic/nbp_range_decode.sv
// nbp_range_decode: maps the protect setting onto one block number.
// assumes block and setting are stable in the caller's clock domain.
`timescale 1ns/1ps
module nbp_range_decode (
  input  wire logic                top_bottom_select,
  input  wire logic [3:0]          protect_range_code,
  input  wire nbp_pkg::nbp_block_t block,
  output logic                     protected_hit
);
  import nbp_pkg::*;

  // ************************************************************
  // range compare
  // ************************************************************
  logic [BLOCK_W-1:0] high_mask;
  logic               all_on;
  logic [4:0]         shift_amt;

  // range is a power of two, so a mask on the upper bits is enough
  always_comb begin
    shift_amt = {1'b0, protect_range_code} + 5'h01;
    high_mask = BLOCK_ONES << shift_amt;
    all_on    = (protect_range_code == CODE_ALL) ||
                (protect_range_code[3:2] == CODE_ALL_HI);
    if (protect_range_code == CODE_RST) begin
      protected_hit = 1'b0;
    end else if (all_on) begin
      protected_hit = 1'b1;
    end else if (top_bottom_select) begin
      protected_hit = (block & high_mask) == '0;
    end else begin
      protected_hit = (block & high_mask) == high_mask;
    end
  end

endmodule

//--- logic/nbp_gate.sv
// nbp_gate: serial instruction framing, protect register and command gate.
// assumes SCK only toggles while CS_N is low and stops before CS_N rises.
`timescale 1ns/1ps
module nbp_gate (
  input  wire logic              MCLK,
  input  wire logic              RESET_N,
  input  wire logic              SCK,
  input  wire logic              CS_N,
  input  wire logic              SERIAL_DATA_IN,
  output logic                   SERIAL_DATA_OUT,
  output logic                   SERIAL_DATA_OE,
  output logic                   BUSY,
  output logic                   WRITE_ENABLED,
  output logic                   TOP_BOTTOM_SELECT,
  output logic [3:0]             PROTECT_RANGE_CODE,
  output logic                   ARRAY_OP_START,
  output nbp_pkg::nbp_opk_t      ARRAY_OP_KIND,
  output nbp_pkg::nbp_page_t     PAGE_ROW_ADDRESS,
  output logic                   CMD_REJECTED
);
  import nbp_pkg::*;

  // ************************************************************
  // state of both domains
  // ************************************************************
  typedef struct packed {
    logic       started;
    logic [2:0] bit_cnt;
    logic [2:0] byte_idx;
    logic [7:0] rx;
    logic [7:0] op;
    logic [7:0] ad0;
    logic [7:0] ad1;
    logic [7:0] ad2;
    logic [7:0] tx;
    logic       tx_on;
    logic       busy_s1;
    logic       busy_s2;
  } nbp_link_t;

  typedef struct packed {
    logic                  cs_s1;
    logic                  cs_s2;
    logic                  cs_s3;
    logic                  wel;
    logic                  tb;
    logic [3:0]            code;
    logic                  busy;
    logic [BUSY_CNT_W-1:0] cnt;
    logic                  start;
    nbp_opk_t              kind;
    nbp_page_t             page;
    logic                  reject;
    logic                  seen;
  } nbp_core_t;

  nbp_link_t  lk_reg;
  nbp_link_t  lk_next;
  nbp_core_t  core_reg;
  nbp_core_t  core_next;
  logic       armed_reg;
  logic       out_bit_reg;
  logic       out_en_reg;
  logic       frame_end;
  logic       whole_bytes;
  logic       prot_hit;
  logic [23:0] raw_page;
  nbp_page_t  req_page;

  // ************************************************************
  // link domain, clocked by the host serial clock
  // ************************************************************
  // armed is preset while chip select is high; first edge of a frame sees it
  always_ff @(posedge SCK or posedge CS_N) begin
    if (CS_N) begin
      armed_reg <= 1'b1;
    end else begin
      armed_reg <= 1'b0;
    end
  end

  // shift in, count bits and bytes, stage the next outgoing byte
  always_comb begin
    logic [2:0] cnt;
    logic [2:0] idx;
    logic [7:0] shifted;
    logic [7:0] op_now;
    logic [7:0] sel;
    logic [2:0] nxt;
    cnt     = armed_reg ? 3'h0 : lk_reg.bit_cnt;
    idx     = armed_reg ? 3'h0 : lk_reg.byte_idx;
    shifted = {lk_reg.rx[6:0], SERIAL_DATA_IN};
    op_now  = (idx == 3'h0) ? shifted : lk_reg.op;
    sel     = (idx == 3'h1) ? shifted : lk_reg.ad0;
    nxt     = (idx == BYTE_IDX_MAX) ? idx : idx + 3'h1;
    lk_next          = lk_reg;
    lk_next.byte_idx = idx;                                // fresh count each frame
    lk_next.busy_s1  = core_reg.busy;
    lk_next.busy_s2  = lk_reg.busy_s1;
    lk_next.started  = armed_reg ? ~lk_reg.started : lk_reg.started; // flips once per frame
    lk_next.rx       = shifted;
    lk_next.bit_cnt  = cnt + 3'h1;
    lk_next.tx       = {lk_reg.tx[6:0], 1'b0};
    lk_next.tx_on    = armed_reg ? 1'b0 : lk_reg.tx_on;
    if (cnt == 3'h7) begin
      // a byte is complete; the first one is the opcode
      unique case (idx)
        3'h0:    lk_next.op  = shifted;
        3'h1:    lk_next.ad0 = shifted;
        3'h2:    lk_next.ad1 = shifted;
        3'h3:    lk_next.ad2 = shifted;
        default: lk_next.op  = lk_reg.op;                  // data bytes pass on
      endcase
      lk_next.byte_idx = nxt;
      lk_next.tx       = 8'h00;
      lk_next.tx_on    = 1'b0;
      if (op_now == OP_READ_ID) begin
        // one dummy byte, then maker and the two part bytes
        lk_next.tx_on = (nxt >= 3'h2) && (nxt <= 3'h4);
        if (nxt == 3'h2) begin
          lk_next.tx = MAKER_CODE;
        end else if (nxt == 3'h3) begin
          lk_next.tx = PART_CODE[15:8];
        end else if (nxt == 3'h4) begin
          lk_next.tx = PART_CODE[7:0];
        end
      end else if ((op_now == OP_RD_SR_A || op_now == OP_RD_SR_B) && nxt >= 3'h2) begin
        // status repeats until chip select rises
        lk_next.tx_on = 1'b1;
        if (sel[7:4] == SR_PROT_SEL) begin
          lk_next.tx[SR1_CODE_LSB+:4] = core_reg.code;
          lk_next.tx[SR1_TB_BIT]      = core_reg.tb;
        end else if (sel[7:4] == SR_STAT_SEL) begin
          lk_next.tx[SR3_BUSY_BIT] = lk_reg.busy_s2;
          lk_next.tx[SR3_WEL_BIT]  = core_reg.wel;
        end
      end
    end
  end

  // captured frame stays put after the last edge for the core to read
  always_ff @(posedge SCK or negedge RESET_N) begin
    if (!RESET_N) begin
      lk_reg <= '0;
    end else begin
      lk_reg <= lk_next;
    end
  end

  // launch on the falling edge so the host samples mid-bit
  always_ff @(negedge SCK or posedge CS_N) begin
    if (CS_N) begin
      out_bit_reg <= 1'b0;
      out_en_reg  <= 1'b0;
    end else begin
      out_bit_reg <= lk_reg.tx[7];
      out_en_reg  <= lk_reg.tx_on;
    end
  end

  assign SERIAL_DATA_OUT = out_bit_reg;
  assign SERIAL_DATA_OE  = out_en_reg;

  // ************************************************************
  // core domain: frame decode, protect register, busy timer
  // ************************************************************
  // a select pulse with no clock must not replay the previous frame
  assign frame_end   = core_reg.cs_s2 & ~core_reg.cs_s3 &
                       (lk_reg.started ^ core_reg.seen);
  assign whole_bytes = (lk_reg.bit_cnt == 3'h0);
  assign raw_page    = {lk_reg.ad0, lk_reg.ad1, lk_reg.ad2};
  assign req_page    = nbp_page_t'(raw_page & PAGE_KEEP_MASK);

  nbp_range_decode u_range (
    .top_bottom_select  (core_reg.tb),
    .protect_range_code (core_reg.code),
    .block              (req_page[BLOCK_LSB+:BLOCK_W]),
    .protected_hit      (prot_hit)
  );

  // link words are only read after chip select has settled high
  always_comb begin
    logic       is_wr;
    logic [2:0] nb;
    core_next        = core_reg;
    core_next.cs_s1  = CS_N;
    core_next.cs_s2  = core_reg.cs_s1;
    core_next.cs_s3  = core_reg.cs_s2;
    core_next.seen   = (core_reg.cs_s2 & ~core_reg.cs_s3) ? lk_reg.started : core_reg.seen;
    core_next.start  = 1'b0;
    core_next.reject = 1'b0;
    nb    = lk_reg.byte_idx;
    is_wr = (lk_reg.op == OP_ERASE) || (lk_reg.op == OP_PROG_EXEC);
    if (core_reg.busy) begin
      core_next.cnt = core_reg.cnt - 1'b1;
      if (core_reg.cnt == BUSY_CNT_W'(1)) begin
        core_next.busy = 1'b0;
        core_next.kind = OPK_NONE;
      end
    end else if (frame_end) begin
      // while busy nothing here runs; reads are served by the link side
      if (whole_bytes && (lk_reg.op == OP_WR_EN)) begin
        core_next.wel = 1'b1;
      end
      if (whole_bytes && (lk_reg.op == OP_WR_DIS)) begin
        core_next.wel = 1'b0;
      end
      if (whole_bytes && (nb >= 3'h3) &&
          (lk_reg.op == OP_WR_SR_A || lk_reg.op == OP_WR_SR_B) &&
          (lk_reg.ad0[7:4] == SR_PROT_SEL)) begin
        core_next.code = lk_reg.ad1[SR1_CODE_LSB+:4];
        core_next.tb   = lk_reg.ad1[SR1_TB_BIT];
      end
      if (whole_bytes && (nb >= 3'h4) && is_wr) begin
        if (core_reg.wel && !prot_hit) begin
          core_next.start = 1'b1;
          core_next.busy  = 1'b1;
          core_next.wel   = 1'b0;
          core_next.page  = req_page;
          core_next.kind  = (lk_reg.op == OP_ERASE) ? OPK_ERASE : OPK_PROG;
          core_next.cnt   = (lk_reg.op == OP_ERASE) ? BUSY_CNT_W'(ERASE_CYC)
                                                   : BUSY_CNT_W'(PROGRAM_CYC);
        end else begin
          core_next.reject = 1'b1;
        end
      end
      // page read may be cut short, it only needs its address bytes
      if ((nb >= 3'h4) && (lk_reg.op == OP_PAGE_READ)) begin
        core_next.start = 1'b1;
        core_next.busy  = 1'b1;
        core_next.page  = req_page;
        core_next.kind  = OPK_READ;
        core_next.cnt   = BUSY_CNT_W'(PAGE_READ_CYC);
      end
    end
  end

  // protect setting resets to nothing protected
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      core_reg       <= '0;
      core_reg.cs_s1 <= 1'b1;
      core_reg.cs_s2 <= 1'b1;
      core_reg.cs_s3 <= 1'b1;
      core_reg.code  <= CODE_RST;
      core_reg.tb    <= TB_RST;
      core_reg.kind  <= OPK_NONE;
    end else begin
      core_reg <= core_next;
    end
  end

  assign BUSY               = core_reg.busy;
  assign WRITE_ENABLED      = core_reg.wel;
  assign TOP_BOTTOM_SELECT  = core_reg.tb;
  assign PROTECT_RANGE_CODE = core_reg.code;
  assign ARRAY_OP_START     = core_reg.start;
  assign ARRAY_OP_KIND      = core_reg.kind;
  assign PAGE_ROW_ADDRESS   = core_reg.page;
  assign CMD_REJECTED       = core_reg.reject;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  logic [BUSY_CNT_W-1:0] busy_len;
  logic [BUSY_CNT_W-1:0] busy_want;

  // measures each busy stretch against the figure for its kind
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      busy_len  <= '0;
      busy_want <= '0;
    end else if (core_reg.start) begin
      busy_len  <= BUSY_CNT_W'(1);
      busy_want <= (core_reg.kind == OPK_ERASE) ? BUSY_CNT_W'(ERASE_CYC) :
                   (core_reg.kind == OPK_PROG)  ? BUSY_CNT_W'(PROGRAM_CYC) :
                                                  BUSY_CNT_W'(PAGE_READ_CYC);
    end else if (core_reg.busy) begin
      busy_len <= busy_len + 1'b1;
    end
  end

  property p_busy_len;
    $fell(BUSY) |-> busy_len == busy_want;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");

  property p_busy_hold;
    ARRAY_OP_START |-> BUSY [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

  property p_busy_ignore;
    frame_end && BUSY |=> $stable({WRITE_ENABLED, TOP_BOTTOM_SELECT, PROTECT_RANGE_CODE})
                          && !ARRAY_OP_START;
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("command taken while busy");

  property p_partial;
    frame_end && !whole_bytes && lk_reg.op != OP_PAGE_READ |=>
      $stable({WRITE_ENABLED, PROTECT_RANGE_CODE}) && !ARRAY_OP_START;
  endproperty
  a_partial: assert property (p_partial) else $error("partial byte frame acted on");

  property p_protect_block;
    frame_end && !BUSY && whole_bytes && lk_reg.byte_idx >= 3'h4 &&
      (lk_reg.op == OP_ERASE || lk_reg.op == OP_PROG_EXEC) && prot_hit
      |=> CMD_REJECTED && !ARRAY_OP_START && !BUSY;
  endproperty
  a_protect_block: assert property (p_protect_block) else $error("protected write ran");

  property p_code_zero;
    PROTECT_RANGE_CODE == CODE_RST |-> !prot_hit;
  endproperty
  a_code_zero: assert property (p_code_zero) else $error("code zero protects");

  property p_top_edge;
    !TOP_BOTTOM_SELECT && PROTECT_RANGE_CODE == 4'h1 |->
      prot_hit == (req_page[BLOCK_LSB+:BLOCK_W] >= 12'hFFC);
  endproperty
  a_top_edge: assert property (p_top_edge) else $error("top range wrong");

  property p_bottom_edge;
    TOP_BOTTOM_SELECT && PROTECT_RANGE_CODE == 4'hA |->
      prot_hit == (req_page[BLOCK_LSB+:BLOCK_W] <= 12'h7FF);
  endproperty
  a_bottom_edge: assert property (p_bottom_edge) else $error("bottom range wrong");

  property p_all;
    PROTECT_RANGE_CODE == CODE_ALL || PROTECT_RANGE_CODE[3:2] == CODE_ALL_HI |-> prot_hit;
  endproperty
  a_all: assert property (p_all) else $error("full protect missed");

  c_erase_run:  cover property (ARRAY_OP_START && ARRAY_OP_KIND == OPK_ERASE);
  c_reject:     cover property (CMD_REJECTED);
  c_busy_frame: cover property (frame_end && BUSY);
  c_sr_write:   cover property ($changed(PROTECT_RANGE_CODE));

endmodule

//--- tb/nbp_host_model.sv
// nbp_host_model: host serial controller that frames instructions for the gate.
// assumes the bench calls xfer one frame at a time and reads back what was shifted out.
`timescale 1ns/1ps
module nbp_host_model (
  output logic     sck,
  output logic     cs_n,
  output logic     sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  // ************************************************************
  // frame driver
  // ************************************************************
  // idle: chip select high, serial clock parked low
  // select pulses once at start so the gate's select-driven presets see an edge
  initial begin
    sck  = 1'b0;
    cs_n = 1'b0;
    sdi  = 1'b0;
    #1 cs_n = 1'b1;
  end

  // one instruction of any bit count; the clock runs only inside the frame
  task automatic xfer(input int nbits, input logic [39:0] tx, output logic [39:0] rx);
    rx = '0;
    cs_n = 1'b0;
    #11;
    for (int i = nbits - 1; i >= 0; i--) begin
      sdi = tx[i];
      #16 sck = 1'b1;
      rx = {rx[38:0], (sdo_oe === 1'b1) ? sdo : 1'bx};
      #16 sck = 1'b0;
    end
    #11 cs_n = 1'b1;
    sdi = ~sdi;                             // released line must not show a stale bit
    #40;                                    // gap well above 4 core cycles
  endtask
endmodule

//--- tb/nbp_gate_tb.sv
// nbp_gate_tb: self-checking bench for the block-protect and command gate.
// assumes nbp_pkg timing constants and the host model driving the serial side.
`timescale 1ns/1ps
module nbp_gate_tb;
  import nbp_pkg::*;
  logic        mclk, reset_n, sck, cs_n, sdi, sdo, sdo_oe, busy, wel, tbs, start, rej;
  logic [3:0]  code;
  nbp_opk_t    kind, last_kind;
  nbp_page_t   page, last_page;
  logic [39:0] rx;
  int          miscompares = 0;
  int          checks_done = 0;
  int          n_start = 0;
  int          n_rej = 0;
  int          busy_len = 0;

  nbp_gate u_dut (.MCLK(mclk), .RESET_N(reset_n), .SCK(sck), .CS_N(cs_n),
    .SERIAL_DATA_IN(sdi), .SERIAL_DATA_OUT(sdo), .SERIAL_DATA_OE(sdo_oe), .BUSY(busy),
    .WRITE_ENABLED(wel), .TOP_BOTTOM_SELECT(tbs), .PROTECT_RANGE_CODE(code),
    .ARRAY_OP_START(start), .ARRAY_OP_KIND(kind), .PAGE_ROW_ADDRESS(page),
    .CMD_REJECTED(rej));
  nbp_host_model u_host (.sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));

  // ************************************************************
  // clock, reset and core-side monitor
  // ************************************************************
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // one-cycle pulses are latched here since frames return long after them
  // sampled mid-cycle, where the registered outputs have settled
  always @(negedge mclk) begin
    if (start === 1'b1) begin
      n_start++;
      last_kind = kind;
      last_page = page;
      busy_len = 0;
    end
    if (rej === 1'b1) n_rej++;
    if (busy === 1'b1) busy_len++;
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic host(input int n, input logic [39:0] tx);
    u_host.xfer(n, tx, rx);
  endtask
  // bounded wait for the array operation to finish
  task automatic wait_idle();
    for (int i = 0; i < 5000; i++) begin
      @(negedge mclk);
      if (busy === 1'b0) return;
    end
    miscompares++;
    $display("[FAIL] %0t busy never fell", $time);
    summarize();
  endtask
  task automatic set_prot(input logic t, input logic [3:0] c);
    host(24, {16'h1FA0, 1'b0, c, t, 2'b00});
    chk(40'({tbs, code}), 40'({t, c}), "protect ports");
    host(24, 40'h0FA000);
    chk(40'(rx[6:2]), 40'({c, t}), "protect readback");
  endtask
  // write enable, then the operation with junk in the ignored page bits
  task automatic run_op(input logic [7:0] op, input logic [11:0] blk, input bit ok,
                        input int len, input nbp_opk_t k);
    int s0;
    int r0;
    s0 = n_start;
    r0 = n_rej;
    host(8, 40'h06);
    host(32, {8'h00, op, 6'h2A, blk, 6'h15});
    chk(40'(n_start - s0), 40'(ok), "start count");
    chk(40'(n_rej - r0), 40'(!ok), "reject count");
    if (ok) begin
      chk(40'(last_kind), 40'(k), "op kind");
      chk(40'(last_page), 40'({blk, 6'h15}), "page address");
      wait_idle();
      chk(40'(busy_len), 40'(len), "busy length");
    end
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    chk(40'({busy, wel, tbs, code, start, rej, sdo_oe}), 40'h0, "reset state");
    $display("test reset done");
  endtask
  // identification read, then a read cut off mid-byte
  task automatic t_ident();
    host(40, 40'h9F00000000);
    chk(40'(rx[23:0]), 40'({MAKER_CODE, PART_CODE}), "id bytes");
    host(21, 40'h13E000);
    chk(40'({sdo_oe, busy, n_start}), 40'h0, "cut read");
    $display("test ident done");
  endtask
  // write-type frames off a byte boundary are dropped whole
  task automatic t_boundary();
    host(7, 40'h03);
    chk(40'(wel), 40'h0, "7-bit enable");
    host(9, 40'h00D);
    chk(40'(wel), 40'h0, "9-bit enable");
    host(8, 40'h06);
    chk(40'(wel), 40'h1, "enable");
    host(33, {7'h0, 8'h10, 24'h000400, 1'b0});
    chk(40'({n_start, n_rej}), 40'h0, "33-bit program");
    chk(40'(wel), 40'h1, "enable kept");
    host(8, 40'h04);
    chk(40'(wel), 40'h0, "disable");
    $display("test boundary done");
  endtask
  // every top/bottom and code: edge protected block refused (codes 1-15), next one accepted (codes 0-10)
  task automatic t_table();
    int n;
    int b;
    for (int t = 0; t < 2; t++) begin
      for (int c = 0; c < 16; c++) begin
        set_prot(t[0], c[3:0]);
        n = (c == 0) ? 0 : (c <= 10) ? (4 << (c - 1)) : 4096;
        if (n > 0) begin
          b = t ? n - 1 : 4096 - n;
          run_op(OP_PROG_EXEC, 12'(b), 0, 0, OPK_PROG);
        end
        if (n < 4096) begin
          b = t ? n : 4095 - n;
          run_op(OP_PROG_EXEC, 12'(b), 1, PROGRAM_CYC, OPK_PROG);
        end
      end
    end
    $display("test table done");
  endtask
  // while busy only status and identification reads are served
  task automatic t_busy();
    int s;
    set_prot(1'b0, 4'h0);
    host(8, 40'h06);
    host(32, {8'h00, OP_ERASE, 24'h000140});
    chk(40'(busy), 40'h1, "erase busy");
    host(8, 40'h06);
    host(24, {16'h1FA0, 8'h58});
    host(24, 40'h0FC000);
    chk(40'(rx[0]), 40'h1, "status busy bit");
    host(40, 40'h9F00000000);
    chk(40'(rx[23:0]), 40'({MAKER_CODE, PART_CODE}), "id busy");
    wait_idle();
    chk(40'(busy_len), 40'(ERASE_CYC), "erase length");
    chk(40'({wel, tbs, code}), 40'h0, "ignored while busy");
    run_op(OP_PAGE_READ, 12'd7, 1, PAGE_READ_CYC, OPK_READ);
    // a select pulse with no clock must not replay the page read
    s = n_start;
    host(0, 40'h0);
    chk(40'(n_start - s), 40'h0, "clockless select");
    $display("test busy done");
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    // starts high so the first fall is a real edge for the async resets
    reset_n = 1'b1;
    @(negedge mclk);
    reset_n = 1'b0;
    repeat (5) @(negedge mclk);
    reset_n = 1'b1;
    repeat (2) @(negedge mclk);
    t_reset();
    t_ident();
    t_boundary();
    t_busy();
    t_table();
    summarize();
  end
endmodule
